// ---- rtl/channel_power_and_group_mapping.sv ----
// channel power sequencing, muting and group mask mapping behind an ahb-lite slave
//
// Contract
// - while reset is asserted the block stays powered down and ignores bus access.
// - after reset the bus works but amplifiers stay off until global power-down clears.
// - a channel powers up only with both global and its own power-down cleared.
// - reset clears every channel power-down flag and sets the global one.
// - channel held muted during amp power-up, then settings applied automatically.
// - a channel powers down when its own or the global power-down flag is set.
// - on power-down the channel is muted first, then the amplifier is stopped.
// - power-related mute and volume changes follow the zero-crossing change mode.
// - reset returns every register to its default value.
// - writes are accepted while global power-down is set; host loads settings then.
// - eight individual volume and mute controls, each fixed to one channel.
// - three group controls change volume or mute of many channels per write.
// - each group has a select mask; a set bit connects that channel.
// - after reset every group mask selects all channels.
// - the group mask governs both group volume and group mute.
// - channel power-down flags live in the channel power register at 0Dh.
// - the global power-down flag is bit 0 of its configuration register.
// - group masks sit at 10h, 13h and 16h.
// - effective volume is individual plus every selecting group volume.
`timescale 1ns/1ns
`default_nettype none

module channel_power_and_group_mapping
  import chan_power_pkg::*;
#(
  parameter int ZC_TIMEOUT_CYCLES = ZC_TIMEOUT_CYCLES_DEF
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire ahb_req_t ahb_i,
  output ahb_rsp_t ahb_o,
  input wire logic [NUM_CH-1:0] zero_cross,
  output chan_out_t [NUM_CH-1:0] chan_o
);

  localparam int TO_W = $clog2(ZC_TIMEOUT_CYCLES + 1);
  localparam logic [TO_W-1:0] TO_LAST = TO_W'(ZC_TIMEOUT_CYCLES - 1);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ch_power;
    logic [7:0] config_r;
    logic [7:0] ch_mute;
    logic [NUM_CH-1:0][7:0] ch_vol;
    logic [NUM_GRP-1:0][7:0] grp_sel;
    logic [NUM_GRP-1:0][7:0] grp_vol;
    logic [NUM_GRP-1:0][7:0] grp_ctl;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
    chan_state_t [NUM_CH-1:0] cst;
    logic [NUM_CH-1:0][7:0] seq_cnt;
    logic [NUM_CH-1:0][TO_W-1:0] zc_cnt;
    logic [NUM_CH-1:0] amp_on;
    logic [NUM_CH-1:0] app_mute;
    logic [NUM_CH-1:0][9:0] app_vol;
  } state_t;

  state_t q;
  state_t d;

  logic take;
  logic [9:0] eff_vol [NUM_CH];
  logic eff_mute [NUM_CH];
  logic [9:0] tgt_vol [NUM_CH];
  logic tgt_mute [NUM_CH];
  logic [NUM_CH-1:0] pdn_mask;

  function automatic logic signed [10:0] sx(input logic [7:0] v);
    sx = {{3{v[7]}}, v};
  endfunction : sx

  assign take = ahb_i.hsel && ahb_i.hready && ahb_i.htrans[1];

  // ---------------------------------------------------------------
  // per-channel mapping of individual and group controls
  // ---------------------------------------------------------------
  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_map
    logic signed [10:0] sum;
    logic gm;
    always_comb
    begin
      sum = sx(q.ch_vol[ch]);
      gm = q.ch_mute[ch];
      for (int g = 0; g < NUM_GRP; g++)
      begin
        if (q.grp_sel[g][ch])
        begin
          sum = sum + sx(q.grp_vol[g]);
          gm = gm | q.grp_ctl[g][CTL_MUTE_BIT];
        end
      end
      // summed before clamping so out-of-range parts may still cancel
      if (sum > VOL_MAX)
        eff_vol[ch] = VOL_MAX[9:0];
      else if (sum < VOL_MIN)
        eff_vol[ch] = VOL_MIN[9:0];
      else
        eff_vol[ch] = sum[9:0];
      eff_mute[ch] = gm;
      // anything but fully on is forced to mute
      tgt_mute[ch] = gm || (q.cst[ch] != CH_ON);
      tgt_vol[ch] = eff_vol[ch];
      pdn_mask[ch] = q.config_r[CFG_GLOBAL_PDN_BIT] | q.ch_power[ch];
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [7:0] idx;
    logic [7:0] wv;
    logic [31:0] rd;
    logic chg;
    logic go;
    idx = ahb_i.haddr[9:2];
    wv = ahb_i.hwdata[7:0];
    rd = 32'h0000_0000;
    chg = 1'b0;
    go = 1'b0;
    d = q;
    // write data phase; accepted whatever the power state
    if (q.wr_pend)
    begin
      if (q.wr_idx >= IDX_CH_VOL_FIRST && q.wr_idx <= IDX_CH_VOL_LAST)
        d.ch_vol[3'(q.wr_idx - IDX_CH_VOL_FIRST)] = wv;
      if (q.wr_idx == IDX_CH_MUTE)
        d.ch_mute = wv;
      if (q.wr_idx == IDX_CH_POWER)
        d.ch_power = wv;
      if (q.wr_idx == IDX_CONFIG)
        d.config_r = wv;
      for (int g = 0; g < NUM_GRP; g++)
      begin
        if (q.wr_idx == IDX_GRP_SEL[g])
          d.grp_sel[g] = wv;
        if (q.wr_idx == IDX_GRP_VOL[g])
          d.grp_vol[g] = wv;
        if (q.wr_idx == IDX_GRP_CTL[g])
          d.grp_ctl[g] = wv;
      end
    end
    d.wr_pend = take && ahb_i.hwrite && (ahb_i.haddr[31:10] == 22'h00_0000);
    d.wr_idx = idx;
    // read mux works on updated values so a read right after a write sees it
    if (take && !ahb_i.hwrite && (ahb_i.haddr[31:10] == 22'h00_0000))
    begin
      if (idx >= IDX_CH_VOL_FIRST && idx <= IDX_CH_VOL_LAST)
        rd[7:0] = d.ch_vol[3'(idx - IDX_CH_VOL_FIRST)];
      if (idx == IDX_CH_MUTE)
        rd[7:0] = d.ch_mute;
      if (idx == IDX_CH_POWER)
        rd[7:0] = d.ch_power;
      if (idx == IDX_CONFIG)
        rd[7:0] = d.config_r;
      if (idx == IDX_STATUS)
      begin
        for (int c = 0; c < NUM_CH; c++)
          rd[c] = (q.cst[c] == CH_ON);
        rd[15:8] = q.amp_on;
      end
      for (int g = 0; g < NUM_GRP; g++)
      begin
        if (idx == IDX_GRP_SEL[g])
          rd[7:0] = d.grp_sel[g];
        if (idx == IDX_GRP_VOL[g])
          rd[7:0] = d.grp_vol[g];
        if (idx == IDX_GRP_CTL[g])
          rd[7:0] = d.grp_ctl[g];
      end
      d.rdata = rd;
    end
    // channel sequencers
    for (int c = 0; c < NUM_CH; c++)
    begin
      chg = (tgt_mute[c] != q.app_mute[c]) || (tgt_vol[c] != q.app_vol[c]);
      go = !q.config_r[CFG_ZC_MODE_BIT] || zero_cross[c] || (q.zc_cnt[c] == TO_LAST);
      if (chg && go)
      begin
        d.app_mute[c] = tgt_mute[c];
        d.app_vol[c] = tgt_vol[c];
        d.zc_cnt[c] = '0;
      end
      else if (chg)
        d.zc_cnt[c] = q.zc_cnt[c] + 1'b1;
      else
        d.zc_cnt[c] = '0;
      case (q.cst[c])
        CH_OFF:
        begin
          d.amp_on[c] = 1'b0;
          if (!pdn_mask[c])
          begin
            d.cst[c] = CH_RAMP_UP;
            d.seq_cnt[c] = 8'h00;
            d.amp_on[c] = 1'b1;
          end
        end
        CH_RAMP_UP:
        begin
          d.seq_cnt[c] = q.seq_cnt[c] + 8'h01;
          if (pdn_mask[c])
            d.cst[c] = CH_MUTING;
          else if (q.seq_cnt[c] == AMP_UP_LAST)
            d.cst[c] = CH_ON;
        end
        CH_ON:
        begin
          if (pdn_mask[c])
            d.cst[c] = CH_MUTING;
        end
        CH_MUTING:
        begin
          // amp keeps running until the mute has really landed
          if (q.app_mute[c])
          begin
            d.cst[c] = CH_RAMP_DOWN;
            d.seq_cnt[c] = 8'h00;
            d.amp_on[c] = 1'b0;
          end
        end
        CH_RAMP_DOWN:
        begin
          d.seq_cnt[c] = q.seq_cnt[c] + 8'h01;
          if (q.seq_cnt[c] == AMP_DN_LAST)
            d.cst[c] = CH_OFF;
        end
        default:
        begin
          d.cst[c] = CH_OFF;
          d.amp_on[c] = 1'b0;
        end
      endcase
    end
    // reset wins over everything, bus included
    if (rst)
    begin
      d = '0;
      d.config_r = RST_CONFIG;
      d.ch_power = RST_CH_POWER;
      d.grp_sel = {NUM_GRP{RST_GRP_SEL}};
      d.app_mute = '1;
    end
  end

  always_ff @(posedge mclk)
  begin
    q <= d;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign ahb_o.hreadyout = 1'b1;
  assign ahb_o.hresp = 1'b0;
  assign ahb_o.hrdata = q.rdata;

  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_out
    assign chan_o[ch].amp_en = q.amp_on[ch];
    assign chan_o[ch].mute = q.app_mute[ch];
    assign chan_o[ch].vol = q.app_vol[ch];
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0] off_mask;
  logic [NUM_CH-1:0] up_mask;
  logic [NUM_CH-1:0] on_mask;
  logic [NUM_CH-1:0] mut_mask;
  logic [NUM_CH-1:0] dn_mask;
  logic tgt_diff0;

  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      off_mask[c] = (q.cst[c] == CH_OFF);
      up_mask[c] = (q.cst[c] == CH_RAMP_UP);
      on_mask[c] = (q.cst[c] == CH_ON);
      mut_mask[c] = (q.cst[c] == CH_MUTING);
      dn_mask[c] = (q.cst[c] == CH_RAMP_DOWN);
    end
    tgt_diff0 = (tgt_mute[0] != q.app_mute[0]) || (tgt_vol[0] != q.app_vol[0]);
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_wr_vol0;
    take && ahb_i.hwrite && (ahb_i.haddr == 32'(IDX_CH_VOL_FIRST) * 4) ##1 1'b1;
  endsequence

  sequence s_up_done0;
    up_mask[0] ##1 on_mask[0];
  endsequence

  sequence s_wr_cfg;
    take && ahb_i.hwrite && (ahb_i.haddr == 32'(IDX_CONFIG) * 4) ##1 1'b1;
  endsequence

  sequence s_wr_power;
    take && ahb_i.hwrite && (ahb_i.haddr == 32'(IDX_CH_POWER) * 4) ##1 1'b1;
  endsequence

  sequence s_wr_sel1;
    take && ahb_i.hwrite && (ahb_i.haddr == 32'(IDX_GRP_SEL[1]) * 4) ##1 1'b1;
  endsequence

  chk_reset_defaults: assert property (disable iff (1'b0) rst |=> (q.config_r == RST_CONFIG && q.ch_power == RST_CH_POWER && q.grp_sel == {NUM_GRP{RST_GRP_SEL}} && !q.wr_pend && q.amp_on == '0))
    else $error("reset defaults wrong");

  chk_global_holds_off: assert property (q.config_r[CFG_GLOBAL_PDN_BIT] |=> (($past(off_mask) & ~off_mask) == '0))
    else $error("channel left off under global power-down");

  chk_leave_needs_both: assert property ((($past(off_mask) & up_mask & $past(pdn_mask)) == '0))
    else $error("channel powered up with power-down set");

  chk_enter_pdn: assert property (((on_mask & pdn_mask) != '0) |=> (($past(on_mask & pdn_mask) & mut_mask) == $past(on_mask & pdn_mask)))
    else $error("channel did not start power-down");

  chk_mute_before_down: assert property (((dn_mask & ~$past(dn_mask) & ~$past(q.app_mute)) == '0) && ((up_mask & ~q.app_mute) == '0))
    else $error("amp moved without mute held");

  chk_up_then_apply: assert property ((s_up_done0 ##0 (!q.config_r[CFG_ZC_MODE_BIT] && !eff_mute[0] && $stable(eff_vol[0]))) |=> (!q.app_mute[0] && q.app_vol[0] == $past(eff_vol[0])))
    else $error("settings not applied after power-up");

  chk_zc_wait: assert property ((q.config_r[CFG_ZC_MODE_BIT] && tgt_diff0 && !zero_cross[0] && q.zc_cnt[0] != TO_LAST) |=> ($stable(q.app_mute[0]) && $stable(q.app_vol[0])))
    else $error("change applied before zero crossing");

  chk_zc_immediate: assert property ((!q.config_r[CFG_ZC_MODE_BIT] && tgt_diff0) |=> (q.app_mute[0] == $past(tgt_mute[0]) && q.app_vol[0] == $past(tgt_vol[0])))
    else $error("immediate change not applied");

  chk_group_mute_map: assert property (((q.grp_sel[0][0] && q.grp_ctl[0][CTL_MUTE_BIT]) |-> eff_mute[0]) and ((!q.ch_mute[0] && q.grp_sel[0][0] == 1'b0 && q.grp_sel[1][0] == 1'b0 && q.grp_sel[2][0] == 1'b0) |-> !eff_mute[0]))
    else $error("group mute mapping wrong");

  chk_write_accepted: assert property (s_wr_vol0 |=> (q.ch_vol[0] == $past(ahb_i.hwdata[7:0]) && q.ch_vol[1] == $past(q.ch_vol[1])))
    else $error("volume write lost or spilled");

  chk_rst_ignores_bus: assert property (disable iff (1'b0) (rst && take && ahb_i.hwrite) |=> !q.wr_pend)
    else $error("bus write taken during reset");

  chk_global_bit: assert property (s_wr_cfg |=> q.config_r[CFG_GLOBAL_PDN_BIT] == $past(ahb_i.hwdata[CFG_GLOBAL_PDN_BIT]))
    else $error("global power-down bit not written");

  chk_power_reg: assert property (s_wr_power |=> q.ch_power == $past(ahb_i.hwdata[7:0]))
    else $error("channel power register not written");

  chk_mask_reg: assert property (s_wr_sel1 |=> (q.grp_sel[1] == $past(ahb_i.hwdata[7:0]) && q.grp_sel[0] == $past(q.grp_sel[0])))
    else $error("group select mask not written");

  chk_amp_by_state: assert property ((((off_mask | dn_mask) & q.amp_on) == '0) && (((up_mask | on_mask | mut_mask) & ~q.amp_on) == '0))
    else $error("amplifier enable disagrees with sequencer state");

  chk_on_needs_clear: assert property (((on_mask & ~$past(on_mask) & $past(pdn_mask)) == '0))
    else $error("channel reached on with power-down set");

endmodule : channel_power_and_group_mapping

`default_nettype wire

// ---- rtl/chan_power_pkg.sv ----
// constants, register map and carrier types for the channel power block
package chan_power_pkg;

  // ---------------------------------------------------------------
  // sizes and clock
  // ---------------------------------------------------------------
  localparam int NUM_CH = 8;
  localparam int NUM_GRP = 3;
  localparam int CLK_PERIOD_NS = 50;

  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_CH_VOL_FIRST = 8'h01;
  localparam logic [7:0] IDX_CH_VOL_LAST = 8'h08;
  localparam logic [7:0] IDX_CH_MUTE = 8'h0A;
  localparam logic [7:0] IDX_CH_POWER = 8'h0D;
  localparam logic [7:0] IDX_CONFIG = 8'h0E;
  localparam logic [7:0] IDX_STATUS = 8'h0F;
  localparam logic [7:0] IDX_GRP_SEL [NUM_GRP] = '{8'h10, 8'h13, 8'h16};
  localparam logic [7:0] IDX_GRP_VOL [NUM_GRP] = '{8'h11, 8'h14, 8'h17};
  localparam logic [7:0] IDX_GRP_CTL [NUM_GRP] = '{8'h12, 8'h15, 8'h18};

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int CFG_GLOBAL_PDN_BIT = 0;
  localparam int CFG_ZC_MODE_BIT = 1;
  localparam int CTL_MUTE_BIT = 1;
  localparam logic [7:0] RST_CONFIG = 8'h01;
  localparam logic [7:0] RST_CH_POWER = 8'h00;
  localparam logic [7:0] RST_GRP_SEL = 8'hFF;

  // ---------------------------------------------------------------
  // volume limits in half-dB steps
  // ---------------------------------------------------------------
  localparam logic signed [10:0] VOL_MAX = 11'sh02C;
  localparam logic signed [10:0] VOL_MIN = -11'sh0C0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int AMP_UP_NS = 1000;
  localparam int AMP_DN_NS = 1000;
  localparam int AMP_UP_CYCLES = (AMP_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AMP_DN_CYCLES = (AMP_DN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] AMP_UP_LAST = 8'(AMP_UP_CYCLES - 1);
  localparam logic [7:0] AMP_DN_LAST = 8'(AMP_DN_CYCLES - 1);
  localparam int ZC_TIMEOUT_US = 5;
  localparam int ZC_TIMEOUT_CYCLES_DEF = ZC_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {CH_OFF, CH_RAMP_UP, CH_ON, CH_MUTING, CH_RAMP_DOWN} chan_state_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } ahb_req_t;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } ahb_rsp_t;

  typedef struct packed {
    logic amp_en;
    logic mute;
    logic [9:0] vol;
  } chan_out_t;

endpackage : chan_power_pkg

// ---- test/ahb_host.sv ----
// host controller model: single-word ahb-lite master for the register port
`timescale 1ns/1ns
`default_nettype none

module ahb_host
  import chan_power_pkg::*;
(
  input wire logic mclk,
  output ahb_req_t req,
  input wire ahb_rsp_t rsp
);
  // ---------------------------------------------------------------
  // bus state
  // ---------------------------------------------------------------
  ahb_req_t r = '0;
  logic [31:0] rd_val;
  event rd_ev;

  always_comb
  begin
    req = r;
    req.hready = rsp.hreadyout;
  end

  // ---------------------------------------------------------------
  // transfer
  // ---------------------------------------------------------------
  // gap idles model a slow host; the slave never waits anyway
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input int gap);
    repeat (gap + 1) @(posedge mclk);
    r.hsel <= 1'b1;
    r.haddr <= {22'h0, idx, 2'h0};
    r.htrans <= HTRANS_NONSEQ;
    r.hwrite <= wr;
    r.hsize <= 3'h2;
    do @(posedge mclk); while (rsp.hreadyout !== 1'b1);
    r.htrans <= 2'h0;
    r.hwdata <= wd;
    do @(posedge mclk); while (rsp.hreadyout !== 1'b1);
    if (!wr)
    begin
      rd_val = rsp.hrdata;
      -> rd_ev;
    end
  endtask : xfer
endmodule : ahb_host

`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for channel power sequencing and group masks
`timescale 1ns/1ns
`default_nettype none

module tb;
  import chan_power_pkg::*;
  logic mclk;
  logic rst;
  logic [NUM_CH-1:0] zero_cross;
  ahb_req_t req;
  ahb_rsp_t rsp;
  chan_out_t [NUM_CH-1:0] chan_o;
  logic [31:0] exp_q [$];
  int miscompares = 0;
  int total_checks = 0;
  int seed = 56676;
  logic signed [7:0] v [NUM_CH];
  logic signed [7:0] gv [NUM_GRP];
  logic [7:0] m [NUM_GRP];
  logic [7:0] pd;
  logic [NUM_CH-1:0] amp_prev = '0;

  // ---------------------------------------------------------------
  // instances and clock
  // ---------------------------------------------------------------
  // short zero-cross timeout keeps the run brief
  channel_power_and_group_mapping #(.ZC_TIMEOUT_CYCLES(16)) DUT (
    .mclk(mclk),
    .rst(rst),
    .ahb_i(req),
    .ahb_o(rsp),
    .zero_cross(zero_cross),
    .chan_o(chan_o)
  );

  ahb_host host (.mclk(mclk), .req(req), .rsp(rsp));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chan_chk(input int c, input logic a, input logic mu);
    chk({31'h0, chan_o[c].amp_en}, {31'h0, a});
    chk({31'h0, chan_o[c].mute}, {31'h0, mu});
  endtask : chan_chk

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    host.xfer(1'b1, idx, d, $unsigned($random(seed)) % 3);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, idx, 32'h0, 0);
  endtask : rd

  function automatic logic [9:0] eff(input int c);
    int s;
    s = v[c];
    for (int g = 0; g < NUM_GRP; g++)
      if (m[g][c])
        s += gv[g];
    // limits apply to the sum, not to each part
    if (s > VOL_MAX)
      s = VOL_MAX;
    if (s < VOL_MIN)
      s = VOL_MIN;
    return 10'(s);
  endfunction : eff

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------
  // watchers
  // ---------------------------------------------------------------
  always @(host.rd_ev)
  begin
    chk(host.rd_val, exp_q.pop_front());
    chk({30'h0, rsp.hreadyout, rsp.hresp}, 32'h2);
  end

  // any amplifier edge must find its channel muted
  always @(negedge mclk)
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (rst === 1'b0 && amp_prev[c] !== chan_o[c].amp_en)
        chk({31'h0, chan_o[c].mute}, 32'h1);
      amp_prev[c] = chan_o[c].amp_en;
    end
  end

  initial
  begin
    repeat (3000) @(posedge mclk);
    miscompares++;
    give_verdict();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst <= 1'b1;
    zero_cross <= '0;
    fork
      repeat (16) @(posedge mclk);
      wr(IDX_CH_POWER, 32'hFF);
    join
    rst <= 1'b0;
    rd(IDX_CONFIG, 32'h1);
    rd(IDX_CH_POWER, 32'h0);
    for (int g = 0; g < NUM_GRP; g++)
      rd(IDX_GRP_SEL[g], 32'hFF);
    pd = 8'($random(seed)) & 8'h0F;
    for (int c = 0; c < NUM_CH; c++)
    begin
      v[c] = 8'($random(seed) % 16);
      wr(IDX_CH_VOL_FIRST + 8'(c), {24'h0, v[c]});
    end
    for (int g = 0; g < NUM_GRP; g++)
    begin
      m[g] = 8'($random(seed));
      gv[g] = 8'($random(seed) % 16);
      wr(IDX_GRP_SEL[g], {24'h0, m[g]});
      wr(IDX_GRP_VOL[g], {24'h0, gv[g]});
      rd(IDX_GRP_SEL[g], {24'h0, m[g]});
    end
    wr(IDX_CH_POWER, {24'h0, pd});
    wr(IDX_CONFIG, 32'h3);
    rd(8'hFF, 32'h0);
    @(negedge mclk);
    for (int c = 0; c < NUM_CH; c++)
      chan_chk(c, 1'b0, 1'b1);
    wr(IDX_CONFIG, 32'h2);
    repeat (26) @(posedge mclk);
    @(negedge mclk);
    for (int c = 0; c < NUM_CH; c++)
      chan_chk(c, !pd[c], 1'b1);
    @(posedge mclk);
    zero_cross <= '1;
    @(posedge mclk);
    zero_cross <= '0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    for (int c = 0; c < NUM_CH; c++)
    begin
      chan_chk(c, !pd[c], pd[c]);
      if (!pd[c])
        chk({22'h0, chan_o[c].vol}, {22'h0, eff(c)});
    end
    rd(IDX_STATUS, {16'h0, ~pd, ~pd});
    wr(IDX_CONFIG, 32'h0);
    wr(IDX_GRP_CTL[0], 32'h2);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    for (int c = 0; c < NUM_CH; c++)
      if (!pd[c])
        chan_chk(c, 1'b1, m[0][c]);
    wr(IDX_CONFIG, 32'h1);
    repeat (30) @(posedge mclk);
    @(negedge mclk);
    for (int c = 0; c < NUM_CH; c++)
      chan_chk(c, 1'b0, 1'b1);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(IDX_GRP_SEL[0], 32'hFF);
    rd(IDX_CH_VOL_FIRST, 32'h0);
    wr(IDX_CH_MUTE, 32'h80);
    wr(IDX_CONFIG, 32'h0);
    repeat (24) @(posedge mclk);
    @(negedge mclk);
    for (int c = 0; c < NUM_CH; c++)
    begin
      chan_chk(c, 1'b1, c == NUM_CH - 1);
      chk({22'h0, chan_o[c].vol}, 32'h0);
    end
    rd(IDX_STATUS, 32'h0000_FFFF);
    repeat (4) @(posedge mclk);
    give_verdict();
  end
endmodule : tb

`default_nettype wire
